//--- hw/adc_chain_device.sv
/*
 * one converter of the daisy chain: mode capture, conversion timer and
 * result shift register feeding the serial output.
 * assumes sample_data is stable while a conversion runs, and that the host
 * gives no serial clock edge during conversion, so the result word and the
 * done flag are static whenever the link-clock logic reads them.
 */
`timescale 1ns/1ps

module adc_chain_device
  import adc_chain_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  adc_chain_if.dev                  link,
  input  wire logic [WORD_BITS-1:0] sample_data,
  input  wire logic                 chain_last,
  output logic                      core_on,
  output logic                      conv_done,
  output logic                      chain_mode,
  output logic                      busy_mode
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ  = 2'b10
  } dev_state_e;

  // system clock domain

  logic [2:0]           pins_sync;
  logic                 conv_s;
  logic                 sck_s;
  logic                 chain_s;

  dev_state_e           state_q;
  dev_state_e           state_d;
  logic                 conv_prev_q;
  logic                 conv_prev_d;
  logic [CNT_W-1:0]     timer_q;
  logic [CNT_W-1:0]     timer_d;
  logic                 chain_mode_q;
  logic                 chain_mode_d;
  logic                 busy_q;
  logic                 busy_d;
  logic                 done_q;
  logic                 done_d;
  logic [WORD_BITS-1:0] result_q;
  logic [WORD_BITS-1:0] result_d;
  logic                 conv_rise;

  bit_sync #(
    .W (3)
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({link.convert_pin, link.sck, link.chain_input}),
    .dout    (pins_sync)
  );

  assign conv_s    = pins_sync[2];
  assign sck_s     = pins_sync[1];
  assign chain_s   = pins_sync[0];
  assign conv_rise = conv_s & ~conv_prev_q;

  always_comb begin
    state_d      = state_q;
    conv_prev_d  = conv_s;
    timer_d      = timer_q;
    chain_mode_d = chain_mode_q;
    busy_d       = busy_q;
    done_d       = done_q;
    result_d     = result_q;
    case (state_q)
      ST_IDLE, ST_ACQ: begin
        if (!conv_s) begin
          done_d = 1'b0;
          if (state_q == ST_ACQ) begin
            state_d = ST_IDLE;
          end
        end
        if (conv_rise) begin
          chain_mode_d = ~chain_s;
          busy_d       = sck_s;
          done_d       = 1'b0;
          timer_d      = CNT_W'(CONV_CYCLES - 1);
          state_d      = ST_CONV;
        end
      end
      ST_CONV: begin
        if (timer_q == '0) begin
          result_d = sample_data;
          done_d   = 1'b1;
          state_d  = ST_ACQ;
        end else begin
          timer_d = timer_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = ST_IDLE;
        done_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= ST_IDLE;
      conv_prev_q  <= 1'b0;
      timer_q      <= '0;
      chain_mode_q <= 1'b1;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      result_q     <= '0;
    end else begin
      state_q      <= state_d;
      conv_prev_q  <= conv_prev_d;
      timer_q      <= timer_d;
      chain_mode_q <= chain_mode_d;
      busy_q       <= busy_d;
      done_q       <= done_d;
      result_q     <= result_d;
    end
  end

  assign core_on    = (state_q == ST_CONV);
  assign conv_done  = done_q;
  assign chain_mode = chain_mode_q;
  assign busy_mode  = busy_q;

  // link clock domain, cleared by the frame itself when convert falls

  logic                 frame_rst;
  logic                 started_q;
  logic                 started_d;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic                 out_bit;

  assign frame_rst = sys_rst | ~link.convert_pin;

  always_comb begin
    started_d = 1'b1;
    if (!started_q) begin
      if (busy_q) begin
        shift_d = result_q;
      end else begin
        shift_d = {result_q[WORD_BITS-2:0], link.chain_input};
      end
    end else begin
      shift_d = {shift_q[WORD_BITS-2:0], link.chain_input};
    end
  end

  always_ff @(negedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      started_q <= 1'b0;
      shift_q   <= '0;
    end else begin
      started_q <= started_d;
      shift_q   <= shift_d;
    end
  end

  always_comb begin
    out_bit = 1'b0;
    if (link.convert_pin && done_q) begin
      if (!started_q) begin
        if (busy_q) begin
          out_bit = chain_last | link.chain_input;
        end else begin
          out_bit = result_q[WORD_BITS-1];
        end
      end else begin
        out_bit = shift_q[WORD_BITS-1];
      end
    end
  end

  assign link.serial_output    = out_bit;
  assign link.serial_output_oe = link.convert_pin ? chain_mode_q : ~link.chain_input;

endmodule

//--- hw/adc_chain_host.sv
/*
 * digital host for the converter chain: drives convert and the serial
 * clock, picks the busy variant by the clock level, and collects words.
 * assumes the chain length matches CHAIN_N and the farthest converter has
 * its chain input tied low.
 */
`timescale 1ns/1ps
module adc_chain_host
  import adc_chain_pkg::*;
#(
  parameter int unsigned CHAIN_N   = CHAIN_LEN,
  parameter int unsigned WAIT_CYCS = HOST_WAIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  adc_chain_if.host                 link,
  input  wire logic                 start,
  input  wire logic                 busy_sel,
  output logic                      ready,
  output logic [WORD_BITS-1:0]      word_data,
  output logic                      word_valid
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_CONV  = 3'b010,
    H_READ  = 3'b011,
    H_END   = 3'b100
  } host_state_e;

  logic                 line_s;
  host_state_e          state_q;
  host_state_e          state_d;
  logic                 conv_q;
  logic                 conv_d;
  logic                 sck_q;
  logic                 sck_d;
  logic                 busy_q;
  logic                 busy_d;
  logic                 skip_q;
  logic                 skip_d;
  logic [CNT_W-1:0]     tmr_q;
  logic [CNT_W-1:0]     tmr_d;
  logic [CNT_W-1:0]     falls_q;
  logic [CNT_W-1:0]     falls_d;
  logic [3:0]           nbit_q;
  logic [3:0]           nbit_d;
  logic [WORD_BITS-1:0] sr_q;
  logic [WORD_BITS-1:0] sr_d;
  logic [WORD_BITS-1:0] word_q;
  logic [WORD_BITS-1:0] word_d;
  logic                 valid_q;
  logic                 valid_d;

  bit_sync #(
    .W (1)
  ) u_line_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (link.serial_line),
    .dout    (line_s)
  );

  always_comb begin
    state_d = state_q;
    conv_d  = conv_q;
    sck_d   = sck_q;
    busy_d  = busy_q;
    skip_d  = skip_q;
    tmr_d   = tmr_q;
    falls_d = falls_q;
    nbit_d  = nbit_q;
    sr_d    = sr_q;
    word_d  = word_q;
    valid_d = 1'b0;
    case (state_q)
      H_IDLE: begin
        if (start) begin
          busy_d  = busy_sel;
          sck_d   = busy_sel;
          tmr_d   = CNT_W'(SETUP_CYC - 1);
          state_d = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tmr_q == '0) begin
          conv_d  = 1'b1;
          tmr_d   = CNT_W'(WAIT_CYCS - 1);
          state_d = H_CONV;
        end else begin
          tmr_d = tmr_q - CNT_W'(1);
        end
      end
      H_CONV: begin
        if (tmr_q != '0) begin
          tmr_d = tmr_q - CNT_W'(1);
        end
        if ((busy_q && line_s) || (!busy_q && tmr_q == '0)) begin
          falls_d = busy_q ? CNT_W'(WORD_BITS * CHAIN_N + 1) : CNT_W'(WORD_BITS * CHAIN_N);
          skip_d  = busy_q;
          nbit_d  = '0;
          tmr_d   = CNT_W'(SCK_HALF_CYC - 1);
          state_d = H_READ;
        end
      end
      H_READ: begin
        if (tmr_q != '0) begin
          tmr_d = tmr_q - CNT_W'(1);
        end else begin
          tmr_d = CNT_W'(SCK_HALF_CYC - 1);
          sck_d = ~sck_q;
          if (sck_q) begin
            falls_d = falls_q - CNT_W'(1);
            skip_d  = 1'b0;
            if (!skip_q) begin
              sr_d   = {sr_q[WORD_BITS-2:0], line_s};
              nbit_d = nbit_q + 4'h1;
              if (nbit_q == 4'hF) begin
                word_d  = {sr_q[WORD_BITS-2:0], line_s};
                valid_d = 1'b1;
              end
            end
            if (falls_q == CNT_W'(1)) begin
              state_d = H_END;
            end
          end
        end
      end
      H_END: begin
        if (tmr_q == '0) begin
          conv_d  = 1'b0;
          state_d = H_IDLE;
        end else begin
          tmr_d = tmr_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = H_IDLE;
        conv_d  = 1'b0;
        sck_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= H_IDLE;
      conv_q  <= 1'b0;
      sck_q   <= 1'b0;
      busy_q  <= 1'b0;
      skip_q  <= 1'b0;
      tmr_q   <= '0;
      falls_q <= '0;
      nbit_q  <= '0;
      sr_q    <= '0;
      word_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      conv_q  <= conv_d;
      sck_q   <= sck_d;
      busy_q  <= busy_d;
      skip_q  <= skip_d;
      tmr_q   <= tmr_d;
      falls_q <= falls_d;
      nbit_q  <= nbit_d;
      sr_q    <= sr_d;
      word_q  <= word_d;
      valid_q <= valid_d;
    end
  end

  assign link.convert_pin = conv_q;
  assign link.sck         = sck_q;
  assign ready            = (state_q == H_IDLE);
  assign word_data        = word_q;
  assign word_valid       = valid_q;

endmodule

//--- hw/adc_chain_if.sv
/*
 * link between the host and the converter nearest to it.
 * assumes the bench drives chain_input of that converter from upstream
 * logic; the serial line reads low when nobody drives it.
 */
`timescale 1ns/1ps
interface adc_chain_if;
  logic convert_pin;
  logic sck;
  logic chain_input;
  logic serial_output;
  logic serial_output_oe;
  logic serial_line;

  assign serial_line = serial_output_oe ? serial_output : 1'b0;

  modport dev (
    input  convert_pin,
    input  sck,
    input  chain_input,
    output serial_output,
    output serial_output_oe
  );

  modport host (
    output convert_pin,
    output sck,
    input  serial_line
  );
endinterface

//--- hw/adc_chain_pkg.sv
/*
 * shared constants for the daisy-chain converter readout: word size, clock
 * rates, conversion and setup times with their derived cycle counts.
 * assumes both ends run their system clock at the rate given here.
 */
package adc_chain_pkg;

  localparam int unsigned WORD_BITS        = 16;
  localparam int unsigned CNT_W            = 16;

  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned SCK_PERIOD_NS    = 125;
  localparam int unsigned SCK_HALF_CYC     = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

  localparam int unsigned CONV_TIME_NS     = 800;
  localparam int unsigned CONV_CYC         = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned HOST_WAIT_NS     = 1000;
  localparam int unsigned HOST_WAIT_CYC    = (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned SETUP_NS         = 20;
  localparam int unsigned SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CHAIN_LEN        = 2;

endpackage

//--- hw/bit_sync.sv
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a quasi-static level; no word coherence is given.
 */
`timescale 1ns/1ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

//--- tb/adc_chain_monitor.sv
/*
 * concurrent checks on the link between the host and the nearest converter.
 * assumes one clock domain for both ends and a chain of CHAIN_N converters.
 */
`timescale 1ns/1ps
module adc_chain_monitor #(
  parameter int unsigned CHAIN_N = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic convert_pin,
  input wire logic sck,
  input wire logic chain_input,
  input wire logic serial_output,
  input wire logic serial_output_oe,
  input wire logic serial_line
);
  localparam int CONV_MAX = 400;
  logic       conv_q, conv_d;
  logic       sck_q, sck_d;
  logic       busy_q, busy_d;
  logic [7:0] falls_q, falls_d;

  // mode latch and falling-edge count per frame
  always_comb begin
    conv_d  = convert_pin;
    sck_d   = sck;
    busy_d  = (convert_pin && !conv_q) ? sck : busy_q;
    falls_d = !convert_pin ? 8'h00 : falls_q + 8'(sck_q && !sck);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_q  <= 1'b0;
      sck_q   <= 1'b0;
      busy_q  <= 1'b0;
      falls_q <= 8'h00;
    end else begin
      conv_q  <= conv_d;
      sck_q   <= sck_d;
      busy_q  <= busy_d;
      falls_q <= falls_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_conv_start;
    $rose(convert_pin);
  endsequence
  sequence s_idle_line;
    !convert_pin && !chain_input;
  endsequence

  a_idle_low: assert property (s_idle_line |-> serial_output_oe && !serial_output)
    else $error("serial output not driven low while idle");
  a_mode_level: assert property (s_conv_start |-> $past(sck, 3) == sck ##1 $stable(sck) [*6])
    else $error("clock level not held around convert rise");
  a_quiet_conv: assert property (s_conv_start |-> !serial_line [*8])
    else $error("serial line high during conversion");
  a_busy_bit: assert property (s_conv_start ##0 sck |-> ##[1:CONV_MAX] serial_line)
    else $error("busy bit never raised");
  a_busy_wait: assert property (convert_pin && busy_q && falls_q == 8'h00 && $fell(sck) |-> $past(serial_line))
    else $error("readout started before busy bit");
  a_rise_hold: assert property (convert_pin && $rose(sck) |-> $stable(serial_line))
    else $error("data moved at clock rise");
  a_fall_hold: assert property (convert_pin && $fell(sck) |-> $past(serial_line) == $past(serial_line, 2))
    else $error("data moved at clock fall");
  a_shift_window: assert property (convert_pin && falls_q != 8'h00 && $changed(serial_line) |-> !sck)
    else $error("data moved outside clock low phase");
  a_frame_clocks: assert property ($fell(convert_pin) |-> falls_q == 8'(16 * CHAIN_N) + 8'(busy_q))
    else $error("wrong clock count in frame");
  a_frame_end: assert property ($fell(convert_pin) |-> !sck && $past(sck, 8) == 1'b0)
    else $error("convert dropped during readback");
endmodule

//--- tb/adc_daisy_chain_readout_tb.sv
/*
 * self-checking bench: host, two chained converters and the link monitor.
 * assumes shortened conversion and wait counts as set below.
 */
`timescale 1ns/1ps
module adc_daisy_chain_readout_tb;
  import adc_chain_pkg::*;

  localparam logic [15:0] CORNER [4] = '{16'h0000, 16'hFFFF, 16'h8001, 16'h7FFE};

  logic                 clk;
  logic                 sys_rst;
  logic                 start;
  logic                 busy_sel;
  logic                 ready;
  logic [WORD_BITS-1:0] word_data;
  logic                 word_valid;
  logic [WORD_BITS-1:0] sample_near;
  logic [WORD_BITS-1:0] sample_far;
  logic                 core_on;
  logic                 conv_done;
  logic                 chain_mode;
  logic                 busy_mode;
  logic [32:0]          wire_bits;
  logic                 far_in;
  logic                 far_chain;
  int                   falls;
  int                   errors;
  int                   checked;

  adc_chain_if link_near ();
  adc_chain_if link_far ();

  assign link_far.convert_pin  = link_near.convert_pin;
  assign link_far.sck          = link_near.sck;
  assign link_far.chain_input  = far_in;
  assign link_near.chain_input = link_far.serial_line;

  adc_chain_host #(.WAIT_CYCS(20)) i_adc_chain_host (
    .clk(clk), .sys_rst(sys_rst), .link(link_near.host), .start(start), .busy_sel(busy_sel),
    .ready(ready), .word_data(word_data), .word_valid(word_valid));
  adc_chain_device #(.CONV_CYCLES(10)) i_adc_chain_device_near (
    .clk(clk), .sys_rst(sys_rst), .link(link_near.dev), .sample_data(sample_near), .chain_last(1'b0),
    .core_on(core_on), .conv_done(conv_done), .chain_mode(chain_mode), .busy_mode(busy_mode));
  adc_chain_device #(.CONV_CYCLES(10)) i_adc_chain_device_far (
    .clk(clk), .sys_rst(sys_rst), .link(link_far.dev), .sample_data(sample_far), .chain_last(1'b1),
    .core_on(), .conv_done(), .chain_mode(far_chain), .busy_mode());
  adc_chain_monitor i_adc_chain_monitor (
    .clk(clk), .sys_rst(sys_rst), .convert_pin(link_near.convert_pin), .sck(link_near.sck),
    .chain_input(link_near.chain_input), .serial_output(link_near.serial_output),
    .serial_output_oe(link_near.serial_output_oe), .serial_line(link_near.serial_line));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // wire capture at every clock fall inside a frame
  always @(negedge link_near.sck) begin
    if (link_near.convert_pin === 1'b1) begin
      falls     = falls + 1;
      wire_bits = {wire_bits[31:0], link_near.serial_line};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // want_word low waits for ready, high for a word pulse
  task automatic wait_for(input bit want_word);
    int n;
    n = 0;
    while ((want_word ? word_valid : ready) !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) errors++;
  endtask

  task automatic run_frame(input logic busy, input logic [15:0] near, input logic [15:0] far);
    logic [15:0] got0;
    logic [15:0] exp_far;
    exp_far     = far_in ? 16'h0000 : far;
    wait_for(1'b0);
    falls       = 0;
    wire_bits   = '0;
    sample_near = near;
    sample_far  = far;
    busy_sel    = busy;
    start       = 1'b1;
    @(negedge clk);
    start       = 1'b0;
    repeat (3) @(negedge clk);
    start       = 1'b1;
    @(negedge clk);
    start       = 1'b0;
    busy_sel    = ~busy;
    wait_for(1'b1);
    got0 = word_data;
    check(busy_mode, busy);
    check(chain_mode, 1'b1);
    check(far_chain, !far_in);
    check({core_on, conv_done}, 2'b01);
    @(negedge clk);
    wait_for(1'b1);
    check(got0, near);
    check(word_data, exp_far);
    wait_for(1'b0);
    check(falls, 32 + busy);
    check(wire_bits[31:0], {near, exp_far});
    check(wire_bits[32], busy);
    repeat (4) @(negedge clk);
    check({ready, link_near.serial_line}, 2'b10);
  endtask

  initial begin
    sys_rst     = 1'b1;
    start       = 1'b0;
    busy_sel    = 1'b0;
    sample_near = '0;
    sample_far  = '0;
    far_in      = 1'b0;
    errors      = 0;
    checked     = 0;
    falls       = 0;
    wire_bits   = '0;
    void'($urandom(94151));
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) run_frame(i[0], CORNER[i], ~CORNER[i]);
    // far converter in chip-select mode: its line stays low, zeros arrive
    far_in = 1'b1;
    run_frame(1'b0, 16'hC3A5, 16'($urandom));
    far_in = 1'b0;
    for (int i = 0; i < 10; i++) run_frame(1'($urandom), 16'($urandom), 16'($urandom));
    // reset in the middle of a busy frame, then a clean frame
    busy_sel = 1'b1;
    start    = 1'b1;
    @(negedge clk);
    start    = 1'b0;
    repeat (100) @(negedge clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    check({ready, link_near.serial_line}, 2'b10);
    run_frame(1'b0, 16'h1234, 16'hABCD);
    end_sim();
  end

  // sixteen frames at about twice their expected length
  initial begin
    #(16 * 2000 * 5);
    errors++;
    end_sim();
  end
endmodule
